// *** core/cwctl_gap.sv ***
// dead band delay counter: delayed rise of a level by a programmed clock count
`timescale 1ns/1ps
module cwctl_gap #(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // level in, gap length, delayed level out
    input  wire logic         lvl_i,
    input  wire logic [W-1:0] gap_i,
    output logic              lvl_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         out_q;
    logic         out_d;

    // count up from zero while level high, release when value reached
    always_comb begin
        cnt_d = cnt_q;
        out_d = 1'b0;
        if (lvl_i) begin
            if (cnt_q >= gap_i) begin
                out_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end else begin
            cnt_d = '0;
        end
    end

    // state registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign lvl_o = out_q;

    // output only rises when the input was high in the cycle before
    a_gap_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(lvl_o) |-> $past(lvl_i)) else $error("gap output rose without input");
endmodule

// *** core/cwctl_pkg.sv ***
// package for the complementary waveform control block: offsets, fields, resets, modes
// Notes on behaviour
// - shutdown: B/D one level, A/C other, no polarity
// - override 11 high, 10 low, 01 float, 00 inactive
// - manual clear only when selected sources low
// - auto restart clears status when sources low
// - overrides hold until first rising input edge
// - control zero bit 7 enables module
// - load bit transfers dead band, then self-clears
// - three-bit mode field decodes six modes
// - read-only bit shows selected input level
// - per-output polarity bit inverts that output
// - rising dead band six bits, reset to zero
// - falling dead band six bits, upper zero
// - status bit reads one during shutdown
// - status write accepted while disabled
// - dead band counts clocks up to value
// - disabled loads now, enabled on next rising or falling input edge
// - shutdown inputs level sensitive, block clearing
package cwctl_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] CWCTL_OFS_CTRL0 = 8'h00;
    localparam logic [7:0] CWCTL_OFS_CTRL1 = 8'h04;
    localparam logic [7:0] CWCTL_OFS_DBR   = 8'h08;
    localparam logic [7:0] CWCTL_OFS_DBF   = 8'h0C;
    localparam logic [7:0] CWCTL_OFS_SDC0  = 8'h10;
    localparam logic [7:0] CWCTL_OFS_SRC   = 8'h14;
    // field positions
    localparam int CWCTL_EN_BIT   = 7;
    localparam int CWCTL_LD_BIT   = 6;
    localparam int CWCTL_IN_BIT   = 5;
    localparam int CWCTL_SD_BIT   = 7;
    localparam int CWCTL_REN_BIT  = 6;
    localparam int CWCTL_BD_OVERRIDE_LEVEL_LSB = 4;
    localparam int CWCTL_AC_OVERRIDE_LEVEL_LSB = 2;
    // reset values
    localparam logic [2:0] CWCTL_MODE_RST = 3'h0;
    localparam logic [3:0] CWCTL_POL_RST  = 4'h0;
    localparam logic [1:0] CWCTL_LS_RST   = 2'h1;
    localparam logic [4:0] CWCTL_SRC_RST  = 5'h00;
    // number of shutdown sources
    localparam int CWCTL_NSRC = 5;
    // override codes
    localparam logic [1:0] CWCTL_LS_HIGH  = 2'h3;
    localparam logic [1:0] CWCTL_LS_LOW   = 2'h2;
    localparam logic [1:0] CWCTL_LS_FLOAT = 2'h1;
    localparam logic [1:0] CWCTL_LS_INACT = 2'h0;
    // operating modes
    typedef enum logic [2:0] {
        CWCTL_M_STEER  = 3'b000,
        CWCTL_M_SSTEER = 3'b001,
        CWCTL_M_FWD    = 3'b010,
        CWCTL_M_REV    = 3'b011,
        CWCTL_M_HALF   = 3'b100,
        CWCTL_M_PUSH   = 3'b101
    } cwctl_mode_t;
endpackage

// *** core/cwctl_top.sv ***
// complementary waveform control: registers, mode logic, dead band, shutdown and restart
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module cwctl_top (
    // clock and reset
    input  wire logic                               REF_CLK_I,
    input  wire logic                               RST_N_I,
    // classic wishbone slave
    input  wire logic                               WB_CYC_I,
    input  wire logic                               WB_STB_I,
    input  wire logic                               WB_WE_I,
    input  wire logic [7:0]                         WB_ADR_I,
    input  wire logic [3:0]                         WB_SEL_I,
    input  wire logic [31:0]                        WB_DAT_I,
    output logic      [31:0]                        WB_DAT_O,
    output logic                                    WB_ACK_O,
    // selected input data and active-low shutdown sources (asynchronous pins)
    input  wire logic                               DATA_I,
    input  wire logic [cwctl_pkg::CWCTL_NSRC-1:0]   SD_N_I,
    // outputs a..d with output enables (low = driving)
    output logic      [3:0]                         OUT_O,
    output logic      [3:0]                         OUT_OE_N_O
);
    import cwctl_pkg::*;

    // synchronised pins
    logic       din_s1_q, din_q, din_prev_q;
    logic [CWCTL_NSRC-1:0] sd_s1_q, sd_q;
    // registers
    logic       en_q, en_d, ld_q, ld_d;
    logic [2:0] mode_q, mode_d;
    logic [3:0] pol_q, pol_d;
    logic [5:0] dbr_q, dbr_d, dbf_q, dbf_d;     // software copies
    logic [5:0] dbra_q, dbra_d, dbfa_q, dbfa_d; // active copies
    logic       sd_st_q, sd_st_d, ren_q, ren_d, hold_q, hold_d;
    logic [1:0] bd_override_level_q, bd_override_level_d, ac_override_level_q, ac_override_level_d;
    logic [CWCTL_NSRC-1:0] srcen_q, srcen_d;
    logic       ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [3:0] out_q, out_d, oen_q, oen_d;
    logic       dir_q, dir_d;
    // combinational helpers
    logic       wr, rd, rise, fall, sd_active, gap_r, gap_f, gap_b, gap_d;
    logic [3:0] raw;
    logic [7:0] wb;

    // byte lane 0 write data, zero when lane not selected
    function automatic logic [7:0] lane0(input logic [31:0] d, input logic [3:0] s);
        return s[0] ? d[7:0] : 8'h00;
    endfunction

    // two-flop synchronisers for pins
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            din_s1_q   <= 1'b0;
            din_q      <= 1'b0;
            din_prev_q <= 1'b0;
            sd_s1_q    <= '1;
            sd_q       <= '1;
        end else begin
            din_s1_q   <= DATA_I;
            din_q      <= din_s1_q;
            din_prev_q <= din_q;
            sd_s1_q    <= SD_N_I;
            sd_q       <= sd_s1_q;
        end
    end

    // bus strobes and edge events
    assign wr   = WB_CYC_I && WB_STB_I && WB_WE_I && ack_q && WB_SEL_I[0]; // lands at the acked edge
    assign rd   = WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_q;
    assign rise = din_q && !din_prev_q;
    assign fall = !din_q && din_prev_q;
    assign sd_active = |(srcen_q & ~sd_q);
    assign wb   = lane0(WB_DAT_I, WB_SEL_I);

    // dead band counters for rising and falling edges
    cwctl_gap #(.W(6)) u_gap_r (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .lvl_i   (din_q),
        .gap_i   (dbra_q),
        .lvl_o   (gap_r)
    );
    cwctl_gap #(.W(6)) u_gap_f (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .lvl_i   (!din_q),
        .gap_i   (dbfa_q),
        .lvl_o   (gap_f)
    );
    // rising-edge delays for full bridge modulated outputs
    cwctl_gap #(.W(6)) u_gap_b (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .lvl_i   (din_q && dir_q),
        .gap_i   (dbra_q),
        .lvl_o   (gap_b)
    );
    cwctl_gap #(.W(6)) u_gap_d (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .lvl_i   (din_q && !dir_q),
        .gap_i   (dbfa_q),
        .lvl_o   (gap_d)
    );

    // register file and control next state
    always_comb begin
        en_d = en_q;
        ld_d = ld_q;
        mode_d = mode_q;
        pol_d = pol_q;
        dbr_d = dbr_q;
        dbf_d = dbf_q;
        dbra_d = dbra_q;
        dbfa_d = dbfa_q;
        sd_st_d = sd_st_q;
        ren_d = ren_q;
        bd_override_level_d = bd_override_level_q;
        ac_override_level_d = ac_override_level_q;
        srcen_d = srcen_q;
        hold_d = hold_q;
        dir_d = dir_q;
        ack_d = (WB_CYC_I && WB_STB_I && !ack_q);
        rdat_d = 32'h0000_0000;
        // buffer transfer on the next input edge
        if (ld_q && (rise || fall)) begin
            dbra_d = dbr_q;
            dbfa_d = dbf_q;
            ld_d   = 1'b0;
        end
        // full bridge direction latched on rising input
        if (rise) begin
            dir_d = mode_q[0];
        end
        // restart: overrides release on first rising edge after status clears
        if (!sd_st_q && hold_q && rise) begin
            hold_d = 1'b0;
        end
        // automatic restart once sources go low
        if (sd_st_q && ren_q && !sd_active) begin
            sd_st_d = 1'b0;
        end
        if (wr) begin
            case (WB_ADR_I)
                CWCTL_OFS_CTRL0: begin
                    en_d   = wb[CWCTL_EN_BIT];
                    ld_d   = ld_d || (wb[CWCTL_LD_BIT] && en_q);
                    mode_d = wb[2:0];
                    if (!wb[CWCTL_EN_BIT]) begin
                        ld_d = 1'b0;
                    end
                end
                CWCTL_OFS_CTRL1: pol_d = wb[3:0];
                CWCTL_OFS_DBR: begin
                    dbr_d = wb[5:0];
                    if (!en_q) begin
                        dbra_d = wb[5:0];
                    end
                end
                CWCTL_OFS_DBF: begin
                    dbf_d = wb[5:0];
                    if (!en_q) begin
                        dbfa_d = wb[5:0];
                    end
                end
                CWCTL_OFS_SDC0: begin
                    ren_d  = wb[CWCTL_REN_BIT];
                    bd_override_level_d = wb[CWCTL_BD_OVERRIDE_LEVEL_LSB +: 2];
                    ac_override_level_d = wb[CWCTL_AC_OVERRIDE_LEVEL_LSB +: 2];
                    if (wb[CWCTL_SD_BIT]) begin
                        sd_st_d = 1'b1;
                    end else if (!sd_active) begin
                        sd_st_d = 1'b0;
                    end
                end
                CWCTL_OFS_SRC: srcen_d = wb[CWCTL_NSRC-1:0];
                default: ;
            endcase
        end
        // hardware shutdown set wins over any clear
        if (sd_active) begin
            sd_st_d = 1'b1;
        end
        if (sd_st_d) begin
            hold_d = 1'b1;
        end
        // read mux, unimplemented bits zero
        if (rd) begin
            case (WB_ADR_I)
                CWCTL_OFS_CTRL0: rdat_d[7:0] = {en_q, ld_q, 3'b000, mode_q};
                CWCTL_OFS_CTRL1: rdat_d[7:0] = {2'b00, din_q, 1'b0, pol_q};
                CWCTL_OFS_DBR:   rdat_d[7:0] = {2'b00, dbr_q};
                CWCTL_OFS_DBF:   rdat_d[7:0] = {2'b00, dbf_q};
                CWCTL_OFS_SDC0:  rdat_d[7:0] = {sd_st_q, ren_q, bd_override_level_q, ac_override_level_q, 2'b00};
                CWCTL_OFS_SRC:   rdat_d[7:0] = {3'b000, srcen_q};
                default:         rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // mode waveform before polarity
    always_comb begin
        raw = 4'h0;
        case (cwctl_mode_t'(mode_q))
            CWCTL_M_STEER, CWCTL_M_SSTEER: raw = {4{din_q}};
            CWCTL_M_FWD:  raw = {gap_d, 1'b0, 1'b0, 1'b1} & {4{dir_q == 1'b0}};
            CWCTL_M_REV:  raw = {1'b0, 1'b1, 1'b0, 1'b0} | {2'b00, gap_b, 1'b0};
            CWCTL_M_HALF: raw = {1'b0, 1'b0, gap_f, gap_r};
            CWCTL_M_PUSH: raw = {1'b0, 1'b0, !din_q, din_q};
            default:      raw = 4'h0;
        endcase
    end

    // output stage: polarity or override levels
    always_comb begin
        out_d = 4'h0;
        oen_d = 4'h0;
        for (int i = 0; i < 4; i++) begin
            logic [1:0] ls;
            ls = (i == 1 || i == 3) ? bd_override_level_q : ac_override_level_q;
            if (hold_q || !en_q) begin
                case (ls)
                    CWCTL_LS_HIGH:  out_d[i] = 1'b1;
                    CWCTL_LS_LOW:   out_d[i] = 1'b0;
                    CWCTL_LS_FLOAT: oen_d[i] = 1'b1;
                    default:        out_d[i] = pol_q[i];
                endcase
            end else begin
                out_d[i] = raw[i] ^ pol_q[i];
            end
        end
    end

    // registers
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            en_q <= 1'b0;
            ld_q <= 1'b0;
            mode_q <= CWCTL_MODE_RST;
            pol_q <= CWCTL_POL_RST;
            dbr_q <= '0;
            dbf_q <= '0;
            dbra_q <= '0;
            dbfa_q <= '0;
            sd_st_q <= 1'b1;
            ren_q <= 1'b0;
            hold_q <= 1'b1;
            dir_q <= 1'b0;
            bd_override_level_q <= CWCTL_LS_RST;
            ac_override_level_q <= CWCTL_LS_RST;
            srcen_q <= CWCTL_SRC_RST;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            out_q <= 4'h0;
            oen_q <= 4'hF;
        end else begin
            en_q <= en_d;
            ld_q <= ld_d;
            mode_q <= mode_d;
            pol_q <= pol_d;
            dbr_q <= dbr_d;
            dbf_q <= dbf_d;
            dbra_q <= dbra_d;
            dbfa_q <= dbfa_d;
            sd_st_q <= sd_st_d;
            ren_q <= ren_d;
            hold_q <= hold_d;
            dir_q <= dir_d;
            bd_override_level_q <= bd_override_level_d;
            ac_override_level_q <= ac_override_level_d;
            srcen_q <= srcen_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            out_q <= out_d;
            oen_q <= oen_d;
        end
    end

    assign WB_ACK_O   = ack_q;
    assign WB_DAT_O   = rdat_q;
    assign OUT_O      = out_q;
    assign OUT_OE_N_O = oen_q;

    // checks
    sequence s_src_low;
        !sd_active;
    endsequence
    a_src_blocks_clr: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        sd_active |=> sd_st_q) else $error("status cleared with source active");
    a_auto_restart: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (sd_st_q && ren_q && !wr) ##0 s_src_low |=> !sd_st_q) else $error("auto restart missed");
    a_manual_hold: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (sd_st_q && !ren_q && !wr) |=> sd_st_q) else $error("status cleared without write");
    a_hold_to_rise: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        $fell(hold_q) |-> $past(rise) && !$past(sd_st_q)) else $error("override released early");
    a_ld_clears: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (ld_q && (rise || fall) && !wr) |=> !ld_q) else $error("load bit not cleared");
    a_ld_needs_en: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        $rose(ld_q) |-> $past(en_q)) else $error("load set while disabled");
    a_over_high: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (hold_q && ac_override_level_q == CWCTL_LS_HIGH) |=> OUT_O[0]) else $error("override high missing");
    a_float_oe: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (hold_q && bd_override_level_q == CWCTL_LS_FLOAT) |=> OUT_OE_N_O[1] && OUT_OE_N_O[3]) else $error("float missing");
    a_bus_ack: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        ack_q |=> !ack_q) else $error("ack longer than one cycle");
    a_dis_over_low: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (!en_q && bd_override_level_q == CWCTL_LS_LOW) |=> !OUT_O[1] && !OUT_O[3]) else $error("override low missing");
    a_dbr_direct: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        (wr && WB_ADR_I == CWCTL_OFS_DBR && !en_q) |=> dbra_q == $past(wb[5:0]))
        else $error("dead band not taken");
endmodule

// *** sim/cwctl_gate_model.sv ***
// gate driver model: each output pin as the power switch driver sees it
`timescale 1ns/1ps
module cwctl_gate_model (
    // clock
    input  wire logic       clk_i,
    // block outputs and their enables (low = driving)
    input  wire logic [3:0] out_i,
    input  wire logic [3:0] oe_n_i,
    // levels seen at the gates
    output logic      [3:0] pad_o
);
    logic [3:0] last_q;
    logic [3:0] last_d;

    // remember the pin levels from the last cycle in which no pin was floated
    always_comb begin
        last_d = oe_n_i ? last_q : out_i;
    end
    always_ff @(posedge clk_i) begin
        last_q <= last_d;
    end

    // a floated pin has no pull, so it wanders: inverse of its last level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pad_o[i] = oe_n_i[i] ? ~last_q[i] : out_i[i];
        end
    end
endmodule

// *** sim/cwctl_top_test.sv ***
// self-checking bench for the complementary waveform control block
`timescale 1ns/1ps
module cwctl_top_test;
    import cwctl_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        data;
    logic        ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] rq;
    logic [4:0]  sd_n;
    logic [3:0]  out;
    logic [3:0]  oe_n;
    logic [3:0]  pad;
    logic [1:0]  c;
    logic [1:0]  n;
    int          fails;
    int          num_checks;

    cwctl_top dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .DATA_I(data), .SD_N_I(sd_n), .OUT_O(out), .OUT_OE_N_O(oe_n));
    cwctl_gate_model gate_u (.clk_i(clk), .out_i(out), .oe_n_i(oe_n), .pad_o(pad));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // compare one value and report a mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        chk({31'h0, ack}, 32'h0000_0000);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rq = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb_xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        wb_xfer(1'b0, a, 8'h00);
        chk(rq, {24'h00_0000, exp});
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // enables, driven levels and gate levels; floated pins are masked
    task automatic pins(input logic [3:0] e_oe, input logic [3:0] e_out);
        chk({20'h0_0000, oe_n, out & ~e_oe, pad & ~e_oe}, {20'h0_0000, e_oe, e_out & ~e_oe, e_out & ~e_oe});
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog well beyond the expected few hundred cycles
    initial begin
        #(25 * 5000);
        fails++;
        end_of_test;
    end

    // main sequence
    initial begin
        clk = 1'b0; rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        sel = 4'hF; wdat = 32'h0000_0000; data = 1'b0; sd_n = 5'h1F; fails = 0; num_checks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        pins(4'hF, 4'h0);
        rd(CWCTL_OFS_CTRL0, 8'h00);
        rd(CWCTL_OFS_SDC0, 8'h94);
        rd(8'h40, 8'h00);
        wr(CWCTL_OFS_DBR, 8'hFF);
        rd(CWCTL_OFS_DBR, 8'h3F);
        wr(CWCTL_OFS_DBF, 8'hFF);
        rd(CWCTL_OFS_DBF, 8'h3F);
        wr(CWCTL_OFS_CTRL1, 8'hFF);
        rd(CWCTL_OFS_CTRL1, 8'h0F);
        data <= 1'b1;
        tick(6);
        rd(CWCTL_OFS_CTRL1, 8'h2F);
        data <= 1'b0;
        tick(6);
        // every override code on both pairs, module disabled, all outputs inverted
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            n = ~c;
            wr(CWCTL_OFS_SDC0, {2'b10, c, n, 2'b00});
            tick(4);
            pins({c == 2'h1, n == 2'h1, c == 2'h1, n == 2'h1}, {c != 2'h2, n != 2'h2, c != 2'h2, n != 2'h2});
        end
        // every defined mode with the module enabled
        for (int k = 0; k < 6; k++) begin
            wr(CWCTL_OFS_CTRL0, {5'b10000, k[2:0]});
            rd(CWCTL_OFS_CTRL0, {5'b10000, k[2:0]});
        end
        wr(CWCTL_OFS_CTRL0, 8'h00);
        // load request in the enabling write is refused, later accepted
        wr(CWCTL_OFS_CTRL0, 8'hC0);
        rd(CWCTL_OFS_CTRL0, 8'h80);
        wr(CWCTL_OFS_CTRL0, 8'hC0);
        rd(CWCTL_OFS_CTRL0, 8'hC0);
        data <= 1'b1;
        tick(6);
        rd(CWCTL_OFS_CTRL0, 8'h80);
        data <= 1'b0;
        tick(6);
        // software restart blocked while a selected source is active
        wr(CWCTL_OFS_CTRL1, 8'h05);
        wr(CWCTL_OFS_SRC, 8'h01);
        sd_n <= 5'h1E;
        tick(4);
        wr(CWCTL_OFS_SDC0, 8'h28);
        rd(CWCTL_OFS_SDC0, 8'hA8);
        sd_n <= 5'h1F;
        tick(4);
        wr(CWCTL_OFS_SDC0, 8'h28);
        rd(CWCTL_OFS_SDC0, 8'h28);
        tick(6);
        pins(4'h0, 4'h0);
        data <= 1'b1;
        tick(6);
        pins(4'h0, 4'hA);
        data <= 1'b0;
        tick(6);
        pins(4'h0, 4'h5);
        // automatic restart once the source goes quiet
        wr(CWCTL_OFS_SDC0, 8'h68);
        sd_n <= 5'h1E;
        tick(4);
        rd(CWCTL_OFS_SDC0, 8'hE8);
        pins(4'h0, 4'h0);
        sd_n <= 5'h1F;
        tick(6);
        rd(CWCTL_OFS_SDC0, 8'h68);
        // forward bridge: a on, d held off for the dead band, then modulated
        wr(CWCTL_OFS_CTRL0, 8'h82);
        data <= 1'b1;
        tick(6);
        pins(4'h0, 4'h4);
        tick(66);
        pins(4'h0, 4'hC);
        data <= 1'b0;
        tick(6);
        pins(4'h0, 4'h4);
        // push-pull: a follows the input, b its inverse
        wr(CWCTL_OFS_CTRL0, 8'h85);
        data <= 1'b1;
        tick(6);
        pins(4'h0, 4'h4);
        data <= 1'b0;
        tick(6);
        pins(4'h0, 4'h7);
        end_of_test;
    end
endmodule
